//--- core/isv_pkg.sv
// Package for the interrupt status and vector readback block.
// Assumes a 32-bit APB slave with three word registers from byte offset zero.
package isv_pkg;
	localparam logic [11:0] ISV_ADDR_STATUS  = 12'h000; // Status and vector register.
	localparam logic [11:0] ISV_ADDR_IRQSTAT = 12'h004; // Sticky event status.
	localparam logic [11:0] ISV_ADDR_IRQMASK = 12'h008; // Event mask.
	localparam int ISV_BIT_REQ   = 15; // Request pending flag position.
	localparam int ISV_BIT_HOLD  = 13; // Vector hold select position.
	localparam int ISV_LVL_LSB   = 8;  // Priority level low bit.
	localparam int ISV_LVL_W     = 4;  // Priority level width.
	localparam int ISV_VEC_W     = 7;  // Vector number width.
	localparam int ISV_EVT_W     = 2;  // Event count: request raised, request acked.
	localparam int ISV_EVT_RAISE = 0;  // Event bit for a new request.
	localparam int ISV_EVT_ACK   = 1;  // Event bit for an acknowledge.
	localparam logic [31:0] ISV_STATUS_USED = 32'h0000af7f; // Implemented status bits.
	localparam int ISV_LANE_HOLD = 1;  // Byte lane that carries the hold bit.
	localparam int ISV_LANE_EVT  = 0;  // Byte lane that carries the event bits.
endpackage

//--- core/isv_flag.sv
// Sticky request flag: set by a raise, cleared by an acknowledge.
// Assumes raise and ack come from logic on pclk.
`timescale 1ns/1ps
module isv_flag (
	input  wire logic pclk,    // System clock.
	input  wire logic presetn, // Asynchronous reset, active low.
	input  wire logic raise,   // Request raised toward the CPU.
	input  wire logic ack,     // CPU acknowledged the request.
	output logic      flag     // Request raised and not yet acked.
);
	// A raise in the same cycle as an ack wins, so a new request is never lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else if (raise) begin
			flag <= 1'b1; // RQ1
		end else if (ack) begin
			flag <= 1'b0; // RQ2
		end
	end
endmodule

//--- core/isv_top.sv
// Interrupt status and vector readback register with an APB slave.
// Assumes the controller supplies pending and acknowledged vectors on pclk.
//
// Functional notes
// RQ1: Bit 15 shows a raised, unacked request.
// RQ2: Flag stays while CPU priority blocks acknowledge.
// RQ3: Writable hold bit 13 selects captured vector.
// RQ4: Hold one captures highest pending vector.
// RQ5: Hold zero captures last acknowledged vector.
// RQ6: Unused bits zero, reset clears, read-only ignored.
`timescale 1ns/1ps
module isv_top (
	input  wire logic        pclk,         // System clock.
	input  wire logic        presetn,      // Asynchronous reset, active low.
	input  wire logic        psel,         // APB select.
	input  wire logic        penable,      // APB access phase.
	input  wire logic        pwrite,       // APB direction.
	input  wire logic [11:0] paddr,        // APB byte address.
	input  wire logic [31:0] pwdata,       // APB write data.
	input  wire logic [3:0]  pstrb,        // APB byte strobes.
	output logic      [31:0] prdata,       // APB read data.
	output logic             pready,       // APB ready, always high.
	output logic             pslverr,      // APB error for unmapped address.
	input  wire logic        req_raise,    // Pulse: request raised toward CPU.
	input  wire logic        req_ack,      // Pulse: CPU acknowledges request.
	input  wire logic [6:0]  pending_vec,  // Highest-priority pending vector.
	input  wire logic [6:0]  acked_vec,    // Vector being acknowledged.
	input  wire logic [3:0]  new_level,    // New CPU priority level.
	output logic             irq           // Level interrupt, unmasked events.
);
	logic                        request_unacked_flag;   // Raised, unacked request.
	logic                        vector_hold_select;     // Hold select control.
	logic [isv_pkg::ISV_VEC_W-1:0] captured_vector_number; // Captured vector.
	logic [isv_pkg::ISV_LVL_W-1:0] new_cpu_priority_level; // Latched priority level.
	logic [isv_pkg::ISV_EVT_W-1:0] evt_stat;               // Sticky event status.
	logic [isv_pkg::ISV_EVT_W-1:0] evt_mask;               // Event mask.
	logic [isv_pkg::ISV_EVT_W-1:0] evt_in;                 // Events this cycle.
	logic                        wr;                     // Write access completes.
	logic                        mapped;                 // Address is decoded.

	// Flag that holds while the CPU has not taken the request. It lives in its
	// own module so that the set-wins rule sits in one place.
	isv_flag u_flag (
		.pclk    (pclk),
		.presetn (presetn),
		.raise   (req_raise),
		.ack     (req_ack),
		.flag    (request_unacked_flag)
	);

	// Write strobe for one register and one byte lane of the write data.
	// Every writable field decodes its own lane, so a narrow write to one
	// lane never disturbs a field that lives in another.
	function automatic logic lane_write(input logic [11:0] addr, input logic [11:0] target,
		input logic [3:0] strb, input int lane);
		return (addr == target) && strb[lane];
	endfunction

	// The slave answers in the first access cycle, so pready never drops.
	assign pready  = 1'b1;
	// Only the three word offsets respond; anything else errors.
	assign mapped  = (paddr == isv_pkg::ISV_ADDR_STATUS) ||
		(paddr == isv_pkg::ISV_ADDR_IRQSTAT) || (paddr == isv_pkg::ISV_ADDR_IRQMASK);
	assign pslverr = psel && penable && !mapped; // Error only in the access phase.
	assign wr      = psel && penable && pwrite && mapped; // Write lands at the access edge.
	assign irq     = |(evt_stat & evt_mask); // Level output, no edge to miss.

	// Events of this cycle, placed at their bit positions.
	always_comb begin
		evt_in                         = '0;
		evt_in[isv_pkg::ISV_EVT_RAISE] = req_raise; // A new request toward the CPU.
		evt_in[isv_pkg::ISV_EVT_ACK]   = req_ack;   // The CPU took a request.
	end

	// Only the hold bit of the status register is writable; the flag, level
	// and vector fields ignore writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_hold_select <= 1'b0; // RQ3
		end else if (wr &&
			lane_write(paddr, isv_pkg::ISV_ADDR_STATUS, pstrb, isv_pkg::ISV_LANE_HOLD)) begin
			vector_hold_select <= pwdata[isv_pkg::ISV_BIT_HOLD]; // RQ3
		end
	end

	// Vector capture follows the hold select. With hold set the field tracks the
	// pending vector one cycle late; with hold clear it moves only on an
	// acknowledge, so software sees the last request that was taken.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			captured_vector_number <= '0; // RQ6
		end else if (vector_hold_select) begin
			captured_vector_number <= pending_vec; // RQ4
		end else if (req_ack) begin
			captured_vector_number <= acked_vec; // RQ5
		end
	end

	// Priority level follows the controller.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			new_cpu_priority_level <= '0; // RQ6
		end else begin
			new_cpu_priority_level <= new_level;
		end
	end

	// Sticky events; a new event wins over a write-one clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_stat <= '0; // RQ6
		end else if (wr &&
			lane_write(paddr, isv_pkg::ISV_ADDR_IRQSTAT, pstrb, isv_pkg::ISV_LANE_EVT)) begin
			evt_stat <= (evt_stat & ~pwdata[isv_pkg::ISV_EVT_W-1:0]) | evt_in;
		end else begin
			evt_stat <= evt_stat | evt_in;
		end
	end

	// Mask register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_mask <= '0; // RQ6
		end else if (wr &&
			lane_write(paddr, isv_pkg::ISV_ADDR_IRQMASK, pstrb, isv_pkg::ISV_LANE_EVT)) begin
			evt_mask <= pwdata[isv_pkg::ISV_EVT_W-1:0];
		end
	end

	// Read data register, loaded in the setup cycle of a read so that it stands
	// through the access phase. Unimplemented bits and unmapped offsets read
	// zero, and writes never touch this register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= '0; // RQ6
			if (paddr == isv_pkg::ISV_ADDR_STATUS) begin
				prdata[isv_pkg::ISV_BIT_REQ]  <= request_unacked_flag; // RQ1
				prdata[isv_pkg::ISV_BIT_HOLD] <= vector_hold_select;
				prdata[isv_pkg::ISV_LVL_LSB +: isv_pkg::ISV_LVL_W] <= new_cpu_priority_level;
				prdata[isv_pkg::ISV_VEC_W-1:0] <= captured_vector_number;
			end else if (paddr == isv_pkg::ISV_ADDR_IRQSTAT) begin
				prdata[isv_pkg::ISV_EVT_W-1:0] <= evt_stat;
			end else if (paddr == isv_pkg::ISV_ADDR_IRQMASK) begin
				prdata[isv_pkg::ISV_EVT_W-1:0] <= evt_mask;
			end
		end
	end

	// Checks below watch the registers that software sees. All of them sleep
	// while reset is low, so a reset in mid-run cannot trip a $past or $stable
	// comparison against a value from before the reset.
	// Flag stays set across cycles without an acknowledge.
	chk_flag_holds: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		request_unacked_flag && !req_ack |=> request_unacked_flag)
		else $error("flag dropped without ack");
	// Raise sets the flag next cycle.
	chk_raise_sets: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		req_raise |=> request_unacked_flag)
		else $error("raise did not set flag");
	// Ack alone clears the flag.
	chk_ack_clears: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		req_ack && !req_raise |=> !request_unacked_flag)
		else $error("ack did not clear flag");
	// Hold write lands.
	chk_hold_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		wr && lane_write(paddr, isv_pkg::ISV_ADDR_STATUS, pstrb, isv_pkg::ISV_LANE_HOLD)
		|=> vector_hold_select == $past(pwdata[isv_pkg::ISV_BIT_HOLD]))
		else $error("hold write lost");
	// Hold tracks pending.
	chk_hold_pending: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		vector_hold_select |=> captured_vector_number == $past(pending_vec))
		else $error("vector not pending one");
	// No hold captures the acked one.
	chk_ack_vector: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
		!vector_hold_select && req_ack |=> captured_vector_number == $past(acked_vec))
		else $error("vector not acked one");
	// No hold and no ack keeps the vector.
	chk_vector_stable: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
		!vector_hold_select && !req_ack |=> $stable(captured_vector_number))
		else $error("vector changed unbidden");
	// Unused bits read zero.
	chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		(prdata & ~isv_pkg::ISV_STATUS_USED) == 32'h00000000)
		else $error("unused bits nonzero");
	// A status read returns the flag as it stood in the setup cycle.
	chk_read_flag: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		psel && !penable && !pwrite && paddr == isv_pkg::ISV_ADDR_STATUS
		|=> prdata[isv_pkg::ISV_BIT_REQ] == $past(request_unacked_flag))
		else $error("flag not read back");
	// A status read returns the captured vector as it stood in the setup cycle.
	chk_read_vector: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		psel && !penable && !pwrite && paddr == isv_pkg::ISV_ADDR_STATUS
		|=> prdata[isv_pkg::ISV_VEC_W-1:0] == $past(captured_vector_number))
		else $error("vector not read back");
	// The hold bit moves only on a write that reaches its byte lane.
	chk_hold_keeps: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		!(wr && lane_write(paddr, isv_pkg::ISV_ADDR_STATUS, pstrb, isv_pkg::ISV_LANE_HOLD))
		|=> $stable(vector_hold_select))
		else $error("hold bit changed unbidden");
	// A write to the status word leaves the level with the controller.
	chk_level_ro: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		wr && paddr == isv_pkg::ISV_ADDR_STATUS |=> new_cpu_priority_level == $past(new_level))
		else $error("level taken from a write");
	// A raise always leaves its sticky event bit set, even against a clear.
	chk_event_sets: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		req_raise |=> evt_stat[isv_pkg::ISV_EVT_RAISE])
		else $error("raise event lost");
	// An acknowledge leaves its sticky event bit set.
	chk_ack_event: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		req_ack |=> evt_stat[isv_pkg::ISV_EVT_ACK])
		else $error("ack event lost");
	// Cover points for the main scenarios.
	cov_raise_ack: cover property (@(posedge pclk) disable iff (!presetn)
		req_raise ##[1:20] req_ack);
	cov_hold_on: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(vector_hold_select));
	cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	cov_ack_capture: cover property (@(posedge pclk) disable iff (!presetn)
		!vector_hold_select && req_ack);
	cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

//--- tb/isv_cpu_model.sv
// CPU core model: acknowledges a raised request when allowed.
// Assumes the bench grants only when CPU priority drops below the request.
`timescale 1ns/1ps
module isv_cpu_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       grant,
	input  wire logic [6:0] vec_in,
	output logic            req_ack,
	output logic      [6:0] acked_vec
);
	// One ack pulse per grant; between acks the vector keeps toggling.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_ack <= 1'b0;
			acked_vec <= 7'h00;
		end else begin
			req_ack <= grant && !req_ack;
			acked_vec <= (grant && !req_ack) ? vec_in : ~acked_vec;
		end
	end
endmodule

//--- tb/tb_isv_top.sv
// Bench for the status and vector readback register.
// Assumes APB answers without wait states but waits on pready anyway.
`timescale 1ns/1ps
module tb_isv_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, req_raise = 1'b0, grant = 1'b0, req_ack, irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr;
	logic [6:0]  pending_vec = 7'h00, cpu_vec = 7'h00, acked_vec;
	logic [3:0]  new_level = 4'h0;
	logic [3:0]  pstrb = 4'hf; // Byte strobes, narrowed once to test lane decode.
	logic [15:0] lf = 16'h4c29;
	logic [32:0] expq[$]; // Expected {pslverr, prdata} per read.
	int          n_mismatch = 0, compares = 0;
	always #25 pclk = ~pclk;
	isv_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .req_raise(req_raise), .req_ack(req_ack),
		.pending_vec(pending_vec), .acked_vec(acked_vec), .new_level(new_level), .irq(irq));
	isv_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .grant(grant), .vec_in(cpu_vec),
		.req_ack(req_ack), .acked_vec(acked_vec));
	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; a read notes its expected answer first.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) expq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Pulses a raise and/or a CPU grant for one cycle.
	task automatic evt(input logic r, input logic g);
		@(posedge pclk);
		req_raise <= r;
		grant <= g;
		@(posedge pclk);
		req_raise <= 1'b0;
		grant <= 1'b0;
	endtask
	// Status word as software should see it.
	function automatic logic [32:0] st(input logic f, input logic h, input logic [3:0] l,
		input logic [6:0] v);
		return {17'h00000, f, 1'b0, h, 1'b0, l, 1'b0, v};
	endfunction
	// Next value of the 16-bit pattern generator.
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic final_report;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Takes the oldest note whenever a read completes.
	always @(posedge pclk) begin
		if (psel && penable)
			chk("pready", {32'h0, pready}, 33'h1);
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
			chk("read", {pslverr, prdata}, expq.pop_front());
	end
	// Watchdog cuts a hang short; the tests need about 110 cycles, 4000 is ample.
	initial begin
		#200000;
		n_mismatch++;
		final_report;
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h000, 0, st(0, 0, 4'h0, 7'h00));
		apb(1, 12'h008, 32'h3, 0);
		new_level <= 4'h9;
		pending_vec <= 7'h55;
		evt(1, 0);
		apb(0, 12'h000, 0, st(1, 0, 4'h9, 7'h00));
		chk("irq", {32'h0, irq}, 33'h1);
		repeat (20) @(posedge pclk);
		apb(0, 12'h000, 0, st(1, 0, 4'h9, 7'h00));
		cpu_vec <= 7'h2a;
		evt(0, 1);
		apb(0, 12'h000, 0, st(0, 0, 4'h9, 7'h2a));
		apb(0, 12'h004, 0, 33'h3);
		apb(1, 12'h004, 32'h3, 0);
		#1 chk("irq", {32'h0, irq}, 33'h0);
		apb(1, 12'h000, 32'hffffffff, 0);
		apb(0, 12'h000, 0, st(0, 1, 4'h9, 7'h55));
		// A write without the hold bit's lane must leave the hold bit alone.
		pstrb <= 4'h1;
		apb(1, 12'h000, 32'h0, 0);
		pstrb <= 4'hf;
		apb(0, 12'h000, 0, st(0, 1, 4'h9, 7'h55));
		for (int i = 0; i < 8; i++) begin
			lf = lfsr_next(lf);
			pending_vec <= lf[6:0];
			new_level <= lf[10:7];
			apb(0, 12'h000, 0, st(0, 1, lf[10:7], lf[6:0]));
		end
		apb(1, 12'h000, 32'h0, 0);
		apb(1, 12'h008, 32'h0, 0);
		cpu_vec <= 7'h13;
		evt(1, 1);
		apb(0, 12'h000, 0, st(0, 0, lf[10:7], 7'h13));
		chk("irq", {32'h0, irq}, 33'h0);
		// Reset in mid-run must clear the hold bit and the sticky events.
		apb(1, 12'h000, 32'h2000, 0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h000, 0, st(0, 0, lf[10:7], 7'h00));
		apb(0, 12'h004, 0, 33'h0);
		apb(0, 12'h00c, 0, {1'b1, 32'h0});
		final_report;
	end
endmodule
